//--- hw/clock_mode_pkg.sv
// Purpose: Constants and types for the system clock and mode control block.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes:   Oscillator pins are sampled on pclk, never used as clocks.
// Summary of operation
// - Clock-select 000..110 gives fast clock divided 1..64, 111 slow.
// - Fast clock comes from fast RC when source bit clear, crystal set.
// - Slow clock always comes from the slow RC oscillator.
// - On slow clock, fast oscillator runs only if its enable bit is set.
// - Six modes: normal, slow run the CPU; sleep, three idles halt it.
// - Slow mode runs the CPU on code 111 with the fast clock off.
// - Halt with both idle enables clear enters sleep; slow RC keeps going.
// - Halt with only slow idle enable set enters the slow-only idle.
// - Halt with both idle enables set enters idle keeping both clocks.
// - Halt with only fast idle enable set enters the fast-only idle.
// - Halted on a fast code, system clock runs only with fast idle set.
// - Halted on code 111, system clock runs only with slow idle set.
// - An enabled fast oscillator with no edge in time resets the device.
// - Unimplemented bits of the system clock control register read zero.
// - Enabling the crystal clears its stable flag until it settles.
// - RC enable or frequency change clears its flag; RC enable resets one.
package clock_mode_pkg;
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] XTAL_ADDR  = 8'h04;
  localparam logic [7:0] FRC_ADDR   = 8'h08;
  localparam logic [7:0] TRIM_ADDR  = 8'h0C;
  localparam logic [7:0] MODE_ADDR  = 8'h10;

  localparam int SEL_LSB   = 5;
  localparam int SRC_BIT   = 3;
  localparam int FIDLE_BIT = 1;
  localparam int SIDLE_BIT = 0;
  localparam int FLAG_BIT  = 1;
  localparam int EN_BIT    = 0;

  localparam logic [2:0] SEL_SLOW    = 3'h7;
  localparam logic [2:0] SEL_RESET   = 3'h0;
  localparam logic       SRC_RESET   = 1'h0;
  localparam logic       IDLE_RESET  = 1'h0;
  localparam logic       XTAL_RESET  = 1'h0;
  localparam logic       FRC_RESET   = 1'h1;
  localparam logic [7:0] TRIM_RESET  = 8'h80;

  localparam int CLK_PERIOD_NS = 40;
  localparam int MISS_TIME_NS  = 2000;
  localparam int MISS_CYCLES   = MISS_TIME_NS / CLK_PERIOD_NS;
  localparam int GAP_W         = 8;
  localparam logic [GAP_W-1:0] MISS_LIMIT = GAP_W'(MISS_CYCLES);

  localparam int STABLE_W          = 11;
  localparam int XTAL_STABLE_EDGES = 1024;
  localparam int FRC_STABLE_EDGES  = 64;
  localparam int SLOW_STABLE_EDGES = 4;

  typedef enum logic [5:0] {
    MODE_NORMAL    = 6'h01,
    MODE_SLOW      = 6'h02,
    MODE_SLEEP     = 6'h04,
    MODE_SLOW_IDLE = 6'h08,
    MODE_BOTH_IDLE = 6'h10,
    MODE_FAST_IDLE = 6'h20
  } op_mode_t;
endpackage

//--- hw/oscillator_monitor.sv
// Purpose: Samples one oscillator pin, counts it stable, spots a stall.
// Assumes: The pin is slower than half of pclk.
// Notes:   The missing check only runs while the oscillator is enabled.
`timescale 1ns/10ps
module oscillator_monitor #(
  parameter int STABLE_EDGES  = 16,   // Edges before stable
  parameter bit CHECK_MISSING = 1'b1  // Watch for a stall
) (
  input  wire logic pclk,       // Block clock
  input  wire logic presetn,    // Async reset, active low
  input  wire logic osc_pin,    // Raw oscillator pin
  input  wire logic run,        // Oscillator enabled
  input  wire logic restart,    // Drop stable and recount
  output logic      edge_seen,  // Rising edge seen
  output logic      stable,     // Oscillator settled
  output logic      missing     // No edge for too long
);
  localparam int SW = clock_mode_pkg::STABLE_W;
  localparam logic [SW-1:0] LAST = SW'(STABLE_EDGES - 1);

  logic          sync1_r;
  logic          sync2_r;
  logic          prev_r;
  logic [SW-1:0] cnt_r;
  logic [clock_mode_pkg::GAP_W-1:0] gap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= osc_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign edge_seen = sync2_r & ~prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      stable <= 1'b0;
    end else if (!run || restart) begin
      cnt_r  <= '0;
      stable <= 1'b0;
    end else if (edge_seen && !stable) begin
      if (cnt_r == LAST) begin
        stable <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= '0;
      missing <= 1'b0;
    end else begin
      if (!run || edge_seen) begin
        gap_r <= '0;
      end else if (gap_r != clock_mode_pkg::MISS_LIMIT) begin
        gap_r <= gap_r + 1'b1;
      end
      missing <= CHECK_MISSING && run &&
                 (gap_r == clock_mode_pkg::MISS_LIMIT);
    end
  end
endmodule

//--- hw/system_clock_mode_control.sv
// Purpose: System clock selection, divide and halt-mode control over APB.
// Assumes: Oscillator pins are slower than half of pclk.
// Notes:   The system clock leaves as a one-cycle tick per clock edge.
`timescale 1ns/10ps
module system_clock_mode_control (
  input  wire logic        pclk,              // APB clock
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped
  input  wire logic        crystal_clk,       // Crystal oscillator pin
  input  wire logic        fast_rc_clk,       // Fast RC oscillator pin
  input  wire logic        slow_rc_clk,       // Slow RC oscillator pin
  input  wire logic        halt_req,          // CPU executes halt
  input  wire logic        wake_req,          // Wake-up event
  output logic             crystal_osc_on,    // Crystal running
  output logic             fast_rc_osc_on,    // Fast RC running
  output logic             slow_rc_osc_on,    // Slow RC running
  output logic      [7:0]  fast_rc_trim,      // Fast RC frequency
  output logic             system_clock_tick, // System clock edge
  output logic             fast_clock_on,     // Fast clock shown on
  output logic             slow_clock_on,     // Slow clock shown on
  output logic             cpu_run,           // CPU clocked
  output logic             device_reset_req   // Whole-device reset
);
  localparam int NOSC = 3;

  logic [2:0]      clock_select_r;
  logic            fast_source_select_r;
  logic            fast_idle_enable_r;
  logic            slow_idle_enable_r;
  logic            crystal_enable_r;
  logic            fast_rc_enable_r;
  logic [2:0]      act_sel_r;
  logic [2:0]      act_sel_nxt;
  logic            act_src_r;
  logic [5:0]      div_cnt_r;
  logic [5:0]      div_mask;
  logic [NOSC-1:0] osc_pin;
  logic [NOSC-1:0] osc_run;
  logic [NOSC-1:0] osc_restart;
  logic [NOSC-1:0] osc_edge;
  logic [NOSC-1:0] osc_stable;
  logic [NOSC-1:0] osc_missing;
  logic            access;
  logic            wr_en;
  logic            rd_hit;
  logic [31:0]     rdata_nxt;
  logic            halted;
  logic            clk_run;
  logic            act_edge;
  logic            act_ok;
  logic            tgt_ok;
  logic            tick_cond;
  logic            pending;
  logic            do_switch;
  logic            fast_osc_keep;
  clock_mode_pkg::op_mode_t mode_r;
  clock_mode_pkg::op_mode_t mode_nxt;

  assign access = psel & penable & ~pready;
  assign wr_en  = psel & penable & pready & pwrite;

  always_comb begin
    rd_hit    = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      clock_mode_pkg::CTRL_ADDR: begin
        rdata_nxt = {24'h00_0000, clock_select_r, 1'b0,
                     fast_source_select_r, 1'b0,
                     fast_idle_enable_r, slow_idle_enable_r};
      end
      clock_mode_pkg::XTAL_ADDR: begin
        rdata_nxt = {30'h0, osc_stable[2], crystal_enable_r};
      end
      clock_mode_pkg::FRC_ADDR: begin
        rdata_nxt = {30'h0, osc_stable[1], fast_rc_enable_r};
      end
      clock_mode_pkg::TRIM_ADDR: begin
        rdata_nxt = {24'h00_0000, fast_rc_trim};
      end
      clock_mode_pkg::MODE_ADDR: begin
        rdata_nxt = {24'h00_0000, slow_clock_on, fast_clock_on, mode_r};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Every access takes one wait state so read data comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~rd_hit;
      if (access && !pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_select_r       <= clock_mode_pkg::SEL_RESET;
      fast_source_select_r <= clock_mode_pkg::SRC_RESET;
      fast_idle_enable_r   <= clock_mode_pkg::IDLE_RESET;
      slow_idle_enable_r   <= clock_mode_pkg::IDLE_RESET;
    end else if (wr_en && paddr == clock_mode_pkg::CTRL_ADDR) begin
      clock_select_r       <= pwdata[clock_mode_pkg::SEL_LSB +: 3];
      fast_source_select_r <= pwdata[clock_mode_pkg::SRC_BIT];
      fast_idle_enable_r   <= pwdata[clock_mode_pkg::FIDLE_BIT];
      slow_idle_enable_r   <= pwdata[clock_mode_pkg::SIDLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_enable_r <= clock_mode_pkg::XTAL_RESET;
      fast_rc_enable_r <= clock_mode_pkg::FRC_RESET;
      fast_rc_trim     <= clock_mode_pkg::TRIM_RESET;
    end else if (wr_en) begin
      if (paddr == clock_mode_pkg::XTAL_ADDR) begin
        crystal_enable_r <= pwdata[clock_mode_pkg::EN_BIT];
      end
      if (paddr == clock_mode_pkg::FRC_ADDR) begin
        fast_rc_enable_r <= pwdata[clock_mode_pkg::EN_BIT];
      end
      if (paddr == clock_mode_pkg::TRIM_ADDR) begin
        fast_rc_trim <= pwdata[7:0];
      end
    end
  end

  // The stable flags drop on enable or retrim so software can poll them.
  assign osc_restart[0] = 1'b0;
  assign osc_restart[1] = wr_en & (((paddr == clock_mode_pkg::TRIM_ADDR) &
                          (pwdata[7:0] != fast_rc_trim)) |
                          ((paddr == clock_mode_pkg::FRC_ADDR) &
                          pwdata[0] & ~fast_rc_enable_r));
  assign osc_restart[2] = wr_en & (paddr == clock_mode_pkg::XTAL_ADDR) &
                          pwdata[0] & ~crystal_enable_r;

  assign osc_pin = {crystal_clk, fast_rc_clk, slow_rc_clk};
  assign osc_run = {crystal_osc_on, fast_rc_osc_on, slow_rc_osc_on};

  generate
    for (genvar i = 0; i < NOSC; i++) begin : g_osc
      oscillator_monitor #(
        .STABLE_EDGES  (i == 2 ? clock_mode_pkg::XTAL_STABLE_EDGES :
                        i == 1 ? clock_mode_pkg::FRC_STABLE_EDGES :
                                 clock_mode_pkg::SLOW_STABLE_EDGES),
        .CHECK_MISSING (i != 0)
      ) u_mon (
        .pclk      (pclk),
        .presetn   (presetn),
        .osc_pin   (osc_pin[i]),
        .run       (osc_run[i]),
        .restart   (osc_restart[i]),
        .edge_seen (osc_edge[i]),
        .stable    (osc_stable[i]),
        .missing   (osc_missing[i])
      );
    end
  endgenerate

  assign halted = (mode_r != clock_mode_pkg::MODE_NORMAL) &&
                  (mode_r != clock_mode_pkg::MODE_SLOW);

  // A fast oscillator keeps its enable bit, even on the slow clock, except while halted with fast idle clear.
  assign fast_osc_keep = ~halted | fast_idle_enable_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_on <= 1'b0;
      fast_rc_osc_on <= 1'b0;
      slow_rc_osc_on <= 1'b0;
    end else begin
      crystal_osc_on <= crystal_enable_r & fast_osc_keep;
      fast_rc_osc_on <= fast_rc_enable_r & fast_osc_keep;
      // Sleep keeps the slow RC for the watchdog; only one idle stops it.
      slow_rc_osc_on <= mode_nxt != clock_mode_pkg::MODE_FAST_IDLE;
    end
  end

  assign act_edge = (act_sel_r == clock_mode_pkg::SEL_SLOW) ?
                    osc_edge[0] :
                    (act_src_r ? osc_edge[2] : osc_edge[1]);
  assign act_ok   = (act_sel_r == clock_mode_pkg::SEL_SLOW) ?
                    osc_stable[0] :
                    (act_src_r ? osc_stable[2] : osc_stable[1]);
  assign tgt_ok   = (clock_select_r == clock_mode_pkg::SEL_SLOW) ?
                    osc_stable[0] :
                    (fast_source_select_r ? osc_stable[2] : osc_stable[1]);

  // Code n below 7 passes one source edge in 2**n; code 7 passes every slow edge.
  assign div_mask  = ~(6'h3F << act_sel_r);
  assign tick_cond = act_edge &
                     ((act_sel_r == clock_mode_pkg::SEL_SLOW) |
                      ((div_cnt_r & div_mask) == 6'h00));

  assign clk_run = ~halted |
                   ((act_sel_r == clock_mode_pkg::SEL_SLOW) ?
                    slow_idle_enable_r :
                    fast_idle_enable_r);

  // Swapping only on a whole output period, or while the clock is stopped
  // or dead, ends the old period whole; the new source then ticks on its first edge.
  assign pending   = {clock_select_r, fast_source_select_r} !=
                     {act_sel_r, act_src_r};
  assign do_switch = pending & tgt_ok &
                     (tick_cond | ~clk_run | ~act_ok);

  // The mode must agree with the source in force after this edge.
  assign act_sel_nxt = do_switch ? clock_select_r : act_sel_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_r <= clock_mode_pkg::SEL_RESET;
      act_src_r <= clock_mode_pkg::SRC_RESET;
      div_cnt_r <= 6'h00;
    end else if (do_switch) begin
      act_sel_r <= clock_select_r;
      act_src_r <= fast_source_select_r;
      div_cnt_r <= 6'h00;
    end else if (act_edge) begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= clk_run & tick_cond;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      clock_mode_pkg::MODE_NORMAL,
      clock_mode_pkg::MODE_SLOW: begin
        if (halt_req) begin
          case ({fast_idle_enable_r, slow_idle_enable_r})
            2'b00:   mode_nxt = clock_mode_pkg::MODE_SLEEP;
            2'b01:   mode_nxt = clock_mode_pkg::MODE_SLOW_IDLE;
            2'b11:   mode_nxt = clock_mode_pkg::MODE_BOTH_IDLE;
            default: mode_nxt = clock_mode_pkg::MODE_FAST_IDLE;
          endcase
        end else if (act_sel_nxt == clock_mode_pkg::SEL_SLOW) begin
          mode_nxt = clock_mode_pkg::MODE_SLOW;
        end else begin
          mode_nxt = clock_mode_pkg::MODE_NORMAL;
        end
      end
      clock_mode_pkg::MODE_SLEEP,
      clock_mode_pkg::MODE_SLOW_IDLE,
      clock_mode_pkg::MODE_BOTH_IDLE,
      clock_mode_pkg::MODE_FAST_IDLE: begin
        if (wake_req) begin
          mode_nxt = (act_sel_nxt == clock_mode_pkg::SEL_SLOW) ?
                     clock_mode_pkg::MODE_SLOW :
                     clock_mode_pkg::MODE_NORMAL;
        end
      end
      default: begin
        mode_nxt = clock_mode_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r        <= clock_mode_pkg::MODE_NORMAL;
      cpu_run       <= 1'b0;
      fast_clock_on <= 1'b0;
      slow_clock_on <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;
      cpu_run       <= (mode_nxt == clock_mode_pkg::MODE_NORMAL) ||
                       (mode_nxt == clock_mode_pkg::MODE_SLOW);
      fast_clock_on <= (mode_nxt == clock_mode_pkg::MODE_NORMAL) ||
                       (mode_nxt == clock_mode_pkg::MODE_BOTH_IDLE) ||
                       (mode_nxt == clock_mode_pkg::MODE_FAST_IDLE);
      slow_clock_on <= mode_nxt != clock_mode_pkg::MODE_FAST_IDLE;
    end
  end

  // The request holds until presetn; the device reset is expected to
  // pull presetn low in turn.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_req <= 1'b0;
    end else if (|osc_missing) begin
      device_reset_req <= 1'b1;
    end
  end

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sleep_entry_a: assert property (
    !halted && halt_req && !fast_idle_enable_r && !slow_idle_enable_r
    |=> mode_r == clock_mode_pkg::MODE_SLEEP && slow_rc_osc_on && !cpu_run)
    else $error("halt with both idle bits clear did not sleep");

  slow_idle_entry_a: assert property (
    !halted && halt_req && !fast_idle_enable_r && slow_idle_enable_r
    |=> mode_r == clock_mode_pkg::MODE_SLOW_IDLE && !fast_clock_on)
    else $error("halt did not enter the slow-only idle");

  both_idle_entry_a: assert property (
    !halted && halt_req && fast_idle_enable_r && slow_idle_enable_r
    |=> mode_r == clock_mode_pkg::MODE_BOTH_IDLE && fast_clock_on &&
        slow_clock_on)
    else $error("halt did not enter the both-clocks idle");

  fast_idle_entry_a: assert property (
    !halted && halt_req && fast_idle_enable_r && !slow_idle_enable_r
    |=> mode_r == clock_mode_pkg::MODE_FAST_IDLE && !slow_clock_on)
    else $error("halt did not enter the fast-only idle");

  slow_mode_a: assert property (
    mode_r == clock_mode_pkg::MODE_SLOW
    |-> act_sel_r == clock_mode_pkg::SEL_SLOW && !fast_clock_on && cpu_run)
    else $error("slow mode without the slow clock");

  halt_fast_a: assert property (
    halted && act_sel_r != clock_mode_pkg::SEL_SLOW && !fast_idle_enable_r
    |=> !system_clock_tick)
    else $error("system clock ran while halted without fast idle");

  halt_slow_a: assert property (
    halted && act_sel_r == clock_mode_pkg::SEL_SLOW && !slow_idle_enable_r
    |=> !system_clock_tick)
    else $error("system clock ran while halted without slow idle");

  reserved_zero_a: assert property (
    pready && !pwrite && paddr == clock_mode_pkg::CTRL_ADDR
    |-> prdata[4] == 1'b0 && prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");

  xtal_restart_a: assert property (
    $rose(crystal_enable_r) |-> !osc_stable[2] [*8])
    else $error("crystal flag not cleared on enable");

  missing_reset_a: assert property (
    |osc_missing |=> device_reset_req [*3])
    else $error("stalled oscillator did not request reset");

  switch_stable_a: assert property (
    $changed({act_sel_r, act_src_r}) &&
    act_sel_r != clock_mode_pkg::SEL_SLOW
    |-> (act_src_r ? $past(osc_stable[2]) : $past(osc_stable[1])))
    else $error("switched to an unstable fast source");

  sleep_seen_c: cover property (mode_r == clock_mode_pkg::MODE_SLEEP);
  both_idle_c:  cover property (mode_r == clock_mode_pkg::MODE_BOTH_IDLE);
  slow_run_c:   cover property (mode_r == clock_mode_pkg::MODE_SLOW ##1
                                system_clock_tick);
  reset_req_c:  cover property ($rose(device_reset_req));
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench for the clock and mode control block.
// Assumes: Oscillator pins are made here from pclk at 1/4, 1/8 and 1/6.
// Notes:   Tick counts allow one tick of slack for phase.
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, halt_req, wake_req;
  logic [7:0]  paddr, fast_rc_trim;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, crystal_clk, fast_rc_clk, slow_rc_clk;
  logic        crystal_osc_on, fast_rc_osc_on, slow_rc_osc_on, cpu_run;
  logic        system_clock_tick, fast_clock_on, slow_clock_on;
  logic        device_reset_req, xtal_run;
  logic [3:0]  oc;
  logic [2:0]  xc;
  int          err_count, samples_checked, cyc, c;
  logic [31:0] st_exp [4] = '{32'h84, 32'h88, 32'h60, 32'hD0};

  system_clock_mode_control i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clk(crystal_clk), .fast_rc_clk(fast_rc_clk),
    .slow_rc_clk(slow_rc_clk), .halt_req(halt_req), .wake_req(wake_req),
    .crystal_osc_on(crystal_osc_on), .fast_rc_osc_on(fast_rc_osc_on),
    .slow_rc_osc_on(slow_rc_osc_on), .fast_rc_trim(fast_rc_trim),
    .system_clock_tick(system_clock_tick), .fast_clock_on(fast_clock_on),
    .slow_clock_on(slow_clock_on), .cpu_run(cpu_run),
    .device_reset_req(device_reset_req));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // A stopped crystal holds its last level, as a dead one would.
  always @(posedge pclk) begin
    oc <= oc + 4'h1;
    fast_rc_clk <= oc[1];
    slow_rc_clk <= oc[2];
    if (xtal_run) begin
      xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
      crystal_clk <= (xc < 3'h3);
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic e);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, er}, {31'h0, e});
  endtask

  task automatic ticks(input int n, input int e);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (system_clock_tick === 1'b1) c++;
    end
    check({31'h0, (c >= e - 1 && c <= e + 1)}, 32'h1);
  endtask

  task automatic pulse(input logic h);
    @(posedge pclk);
    if (h) halt_req <= 1'b1; else wake_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, halt_req, wake_req} = 6'h00;
    {paddr, pwdata, oc, xc, xtal_run} = 48'h0;
    {crystal_clk, fast_rc_clk, slow_rc_clk} = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h00, 32'h00, 1'b0);
    rd_chk(8'h04, 32'h00, 1'b0);
    rd_chk(8'h08, 32'h01, 1'b0);
    rd_chk(8'h0C, 32'h80, 1'b0);
    repeat (300) @(posedge pclk);
    rd_chk(8'h08, 32'h03, 1'b0);
    rd_chk(8'h10, 32'hC1, 1'b0);
    rd_chk(8'h20, 32'h00, 1'b1);
    xfer(1'b1, 8'h10, 32'h0);
    rd_chk(8'h10, 32'hC1, 1'b0);
    xfer(1'b1, 8'h00, 32'hFFFFFFFF);
    rd_chk(8'h00, 32'hEB, 1'b0);
    repeat (50) @(posedge pclk);
    rd_chk(8'h10, 32'h82, 1'b0);
    xfer(1'b1, 8'h08, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, fast_rc_osc_on}, 32'h0);
    xfer(1'b1, 8'h08, 32'h1);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, 8'h00, 32'(k) << 5);
      repeat (400) @(posedge pclk);
      ticks(512, (k == 7) ? 64 : 128 >> k);
    end
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, 8'h00, ((k < 4) ? 32'h00 : 32'hE0) | 32'(k % 4));
      repeat (300) @(posedge pclk);
      pulse(1'b1);
      rd_chk(8'h10, st_exp[k % 4], 1'b0);
      check({31'h0, cpu_run}, 32'h0);
      check({31'h0, fast_rc_osc_on}, 32'(k % 4 / 2));
      check({31'h0, slow_rc_osc_on}, 32'(k % 4 != 2));
      ticks(100, (k < 4) ? k / 2 * 25 : k % 2 * 12);
      check(32'(c != 0), 32'((k < 4) ? k / 2 : k % 2));
      pulse(1'b0);
      check({31'h0, cpu_run}, 32'h1);
      repeat (300) @(posedge pclk);
    end
    xfer(1'b1, 8'h00, 32'h00);
    xtal_run <= 1'b1;
    xfer(1'b1, 8'h04, 32'h1);
    rd_chk(8'h04, 32'h01, 1'b0);
    check({31'h0, crystal_osc_on}, 32'h1);
    repeat (6500) @(posedge pclk);
    rd_chk(8'h04, 32'h03, 1'b0);
    xfer(1'b1, 8'h00, 32'h08);
    repeat (100) @(posedge pclk);
    ticks(600, 100);
    xfer(1'b1, 8'h0C, 32'h55);
    rd_chk(8'h08, 32'h01, 1'b0);
    check({24'h0, fast_rc_trim}, 32'h55);
    repeat (300) @(posedge pclk);
    rd_chk(8'h08, 32'h03, 1'b0);
    xtal_run <= 1'b0;
    repeat (40) @(posedge pclk);
    check({31'h0, device_reset_req}, 32'h0);
    repeat (30) @(posedge pclk);
    check({31'h0, device_reset_req}, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h00, 32'h00, 1'b0);
    check({31'h0, device_reset_req}, 32'h0);
    tally_and_finish();
  end
endmodule
